// ===== core/pscr_consts.vh
`ifndef PSCR_CONSTS_VH
`define PSCR_CONSTS_VH

// byte register addresses of the indirect access path
`define PSCR_REG_SELECT 8'h6E
`define PSCR_REG_INDEX 8'h6F
`define PSCR_REG_DATA3 8'h75
`define PSCR_REG_DATA2 8'h76
`define PSCR_REG_DATA1 8'h77
`define PSCR_REG_DATA0 8'h78

// select codes written to the select register
`define PSCR_SEL_PORT_STATS 8'h1C
`define PSCR_SEL_DROP_STATS 8'h1D

// statistics word fields
`define PSCR_OVF_BIT 31
`define PSCR_VALID_BIT 30
`define PSCR_COUNT_W 30
`define PSCR_DROP_W 16

// counter map
`define PSCR_PORTS 5
`define PSCR_PER_PORT 32
`define PSCR_PORT_STRIDE 9'h020
`define PSCR_RX64_OFFSET 5'h0E
`define PSCR_DROP_TX_BASE 9'h100
`define PSCR_DROP_RX_BASE 9'h105
`define PSCR_DROP_LAST 9'h109

// reset values
`define PSCR_SELECT_RST 8'h00
`define PSCR_INDEX_RST 8'h00
`define PSCR_DATA_RST 32'h00000000

`endif

// ===== core/pscr_stat_counter.v
`include "pscr_consts.vh"

module pscr_stat_counter #(
  parameter W = `PSCR_COUNT_W
) (
  input wire clk, // core clock
  input wire rst, // synchronous reset, active high
  input wire inc, // count one event
  input wire clr, // read-clear strobe
  output reg [W-1:0] value, // current count
  output reg ovf // wrapped since last clear
);

  always @(posedge clk) begin
    if (rst) begin
      value <= {W{1'b0}};
      ovf <= 1'b0;
    end else if (clr) begin
      // an event in the clear cycle survives as the first count
      value <= inc ? {{(W-1){1'b0}}, 1'b1} : {W{1'b0}};
      ovf <= 1'b0;
    end else if (inc) begin
      value <= value + {{(W-1){1'b0}}, 1'b1};
      if (&value) begin
        ovf <= 1'b1;
      end
    end
  end

endmodule // pscr_stat_counter

// ===== core/pscr_drop_counter.v
`include "pscr_consts.vh"

module pscr_drop_counter #(
  parameter W = `PSCR_DROP_W
) (
  input wire clk, // core clock
  input wire rst, // synchronous reset, active high
  input wire inc, // one discarded frame
  output reg [W-1:0] value // free-running count
);

  // no clear input: reading leaves it alone, wrap is silent
  always @(posedge clk) begin
    if (rst) begin
      value <= {W{1'b0}};
    end else if (inc) begin
      value <= value + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // pscr_drop_counter

// ===== core/pscr_stats_readout.v
// Summary of operation
// - traffic word: bit31 overflow, bit30 valid, bits 29-0 count, reset zero
// - overflow bit set when a traffic counter wraps past maximum
// - egress discard counts for ports one to five at indices 0x100-0x104
// - ingress discard counts for ports one to five at indices 0x105-0x109
// - discard counter is 16 bits, upper bits reserved, no overflow or valid
// - thirty-four counters per port: thirty-two traffic plus two discard
// - write 0x1c to register 110, then index to 111 starts fetch
// - index is port base plus counter offset, e.g. 0x2e
// - result bytes in registers 117 (bits 31-24) to 120 (bits 7-0)
// - select 0x1d plus low index byte reads a discard counter
// - reading a traffic counter clears it
// - reading a discard counter leaves it unchanged
// - port blocks based at 0x00, 0x20, 0x40, 0x60, 0x80, 32 offsets each
// - offset 0xE counts received frames of exactly 64 octets
`include "pscr_consts.vh"

module pscr_stats_readout #(
  parameter PORTS = `PSCR_PORTS,
  parameter PER_PORT = `PSCR_PER_PORT
) (
  input wire clk, // core clock
  input wire rst, // synchronous reset, active high
  input wire [7:0] reg_addr, // byte register address
  input wire reg_wr, // write strobe, one cycle
  input wire [7:0] reg_wdata, // write data
  input wire reg_rd, // read strobe, one cycle
  output reg [7:0] reg_rdata, // read data, valid cycle after reg_rd
  input wire [PORTS*PER_PORT-1:0] stat_inc, // per-counter event pulses
  input wire [PORTS-1:0] egress_discard_inc, // tx frame dropped, per port
  input wire [PORTS-1:0] ingress_discard_inc, // rx frame dropped, per port
  output wire fetch_busy // fetch in flight
);

  localparam NSTAT = PORTS * PER_PORT;
  localparam NDROP = 2 * PORTS;
  localparam ST_IDLE = 1'b0;
  localparam ST_FETCH = 1'b1;

  reg [7:0] select_code;
  reg [7:0] index_byte;
  reg [8:0] fetch_index;
  reg state;
  reg [31:0] data_word;
  reg [31:0] next_data_word;
  reg next_state;
  reg [31:0] traffic_capture;
  reg [31:0] drop_capture;

  wire [32*NSTAT-1:0] stat_words;
  wire [`PSCR_DROP_W*NDROP-1:0] drop_words;
  wire [NSTAT-1:0] stat_clr;
  wire sel_wr;
  wire idx_wr;
  wire fetch_go;
  wire data_rd;
  wire [7:0] data_off;
  wire [2:0] fetch_port;
  wire [4:0] fetch_offset;
  wire [3:0] drop_slot;

  // traffic index lies inside the five port blocks
  function stat_hit;
    input [8:0] idx;
    begin
      stat_hit = (idx[8] == 1'b0) && (idx < NSTAT);
    end
  endfunction

  // discard index lies in the tx-then-rx table
  function drop_hit;
    input [8:0] idx;
    begin
      drop_hit = (idx >= `PSCR_DROP_TX_BASE) && (idx <= `PSCR_DROP_LAST);
    end
  endfunction

  // the select register names which table the index byte points into
  function sel_known;
    input [7:0] code;
    begin
      sel_known = (code == `PSCR_SEL_PORT_STATS) || (code == `PSCR_SEL_DROP_STATS);
    end
  endfunction

  function sel_drop;
    input [7:0] code;
    begin
      sel_drop = (code == `PSCR_SEL_DROP_STATS);
    end
  endfunction

  // register address decode, shared by the write and read paths
  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // byte lane of the captured word, most significant lane at the lowest address
  function [7:0] lane_byte;
    input [31:0] word;
    input [1:0] lane;
    begin
      case (lane)
        2'h0: lane_byte = word[31:24];
        2'h1: lane_byte = word[23:16];
        2'h2: lane_byte = word[15:8];
        default: lane_byte = word[7:0];
      endcase
    end
  endfunction

  assign fetch_busy = (state == ST_FETCH);
  assign sel_wr = reg_wr && addr_is(reg_addr, `PSCR_REG_SELECT);
  assign idx_wr = reg_wr && addr_is(reg_addr, `PSCR_REG_INDEX);
  assign fetch_go = idx_wr && sel_known(select_code);
  assign data_off = reg_addr - `PSCR_REG_DATA3;
  assign data_rd = (reg_addr >= `PSCR_REG_DATA3) && (reg_addr <= `PSCR_REG_DATA0);
  // index splits into port block and offset inside it
  assign fetch_port = fetch_index[7:5];
  assign fetch_offset = fetch_index[4:0];
  assign drop_slot = fetch_index[3:0];

  // one cell per traffic counter; offset 0xE of each block is the
  // 64-octet receive count, fed by its own event line
  genvar gi;
  generate
    for (gi = 0; gi < NSTAT; gi = gi + 1) begin : g_stat
      wire [`PSCR_COUNT_W-1:0] cnt;
      wire ovf;
      assign stat_clr[gi] = (state == ST_FETCH) && stat_hit(fetch_index)
                            && (fetch_index[7:0] == gi);
      pscr_stat_counter #(
        .W(`PSCR_COUNT_W)
      ) u_cnt (
        .clk(clk),
        .rst(rst),
        .inc(stat_inc[gi]),
        .clr(stat_clr[gi]),
        .value(cnt),
        .ovf(ovf)
      );
      assign stat_words[32*gi +: 32] = {ovf, 1'b0, cnt};
    end
    // egress discards fill the lower half of the table, ingress the upper
    for (gi = 0; gi < PORTS; gi = gi + 1) begin : g_drop
      pscr_drop_counter #(
        .W(`PSCR_DROP_W)
      ) u_egress (
        .clk(clk),
        .rst(rst),
        .inc(egress_discard_inc[gi]),
        .value(drop_words[`PSCR_DROP_W*gi +: `PSCR_DROP_W])
      );
      pscr_drop_counter #(
        .W(`PSCR_DROP_W)
      ) u_ingress (
        .clk(clk),
        .rst(rst),
        .inc(ingress_discard_inc[gi]),
        .value(drop_words[`PSCR_DROP_W*(PORTS+gi) +: `PSCR_DROP_W])
      );
    end
  endgenerate

  // traffic word as handed over: overflow and count as held, valid set
  always @* begin
    traffic_capture = stat_words[{fetch_port, fetch_offset, 5'b00000} +: 32];
    traffic_capture[`PSCR_VALID_BIT] = 1'b1;
  end

  // discard word: reserved bits and both flags read as zero
  always @* begin
    drop_capture = `PSCR_DATA_RST;
    drop_capture[`PSCR_DROP_W-1:0] = drop_words[{drop_slot, 4'h0} +: `PSCR_DROP_W];
  end

  // capture word: indices outside both tables capture zero, valid low
  always @* begin
    next_data_word = `PSCR_DATA_RST;
    if (stat_hit(fetch_index)) begin
      next_data_word = traffic_capture;
    end else if (drop_hit(fetch_index)) begin
      next_data_word = drop_capture;
    end
  end

  // next state: a capture always takes exactly one cycle
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (fetch_go) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // a trigger in the capture cycle queues the next capture right behind it
        next_state = fetch_go ? ST_FETCH : ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // fetch sequencer: the index write starts, the next edge captures
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      select_code <= `PSCR_SELECT_RST;
      index_byte <= `PSCR_INDEX_RST;
      fetch_index <= 9'h000;
      data_word <= `PSCR_DATA_RST;
    end else begin
      state <= next_state;
      if (state == ST_FETCH) begin
        data_word <= next_data_word;
      end
      if (sel_wr) begin
        select_code <= reg_wdata;
      end
      if (idx_wr) begin
        index_byte <= reg_wdata;
      end
      // unknown select codes store the index but fetch nothing
      if (fetch_go) begin
        fetch_index <= {sel_drop(select_code), reg_wdata};
        data_word[`PSCR_VALID_BIT] <= 1'b0;
      end
    end
  end

  // byte reads; data bytes are plain reads, the clear already happened
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (data_rd) begin
        reg_rdata <= lane_byte(data_word, data_off[1:0]);
      end else if (addr_is(reg_addr, `PSCR_REG_SELECT)) begin
        reg_rdata <= select_code;
      end else if (addr_is(reg_addr, `PSCR_REG_INDEX)) begin
        reg_rdata <= index_byte;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule // pscr_stats_readout

// ===== tb/pscr_stats_readout_sva.sv
module pscr_sva #(
  parameter PORTS = 5,
  parameter PER_PORT = 32
) (
  input wire clk, // clock
  input wire rst, // reset
  input wire [7:0] reg_addr, // address
  input wire reg_wr, // write
  input wire [7:0] reg_wdata, // wdata
  input wire reg_rd, // read
  input wire [7:0] reg_rdata, // rdata
  input wire [PORTS*PER_PORT-1:0] stat_inc, // events
  input wire [PORTS-1:0] egress_discard_inc, // tx drops
  input wire [PORTS-1:0] ingress_discard_inc, // rx drops
  input wire fetch_busy // busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reg [7:0] sel;
  always @(posedge clk) sel <= rst ? 8'h00 : (reg_wr && reg_addr == 8'h6E) ? reg_wdata : sel;
  wire idx_wr = reg_wr && reg_addr == 8'h6F;
  wire go = idx_wr && (sel == 8'h1C || sel == 8'h1D);
  sequence s_trig; idx_wr && sel == 8'h1C && reg_wdata < 8'hA0; endsequence
  sequence s_top; reg_rd && reg_addr == 8'h75; endsequence
  property p_busy; go |=> fetch_busy ##1 (!fetch_busy || $past(go)); endproperty
  property p_idle; !go |=> !fetch_busy; endproperty
  property p_sel_rd; reg_rd && reg_addr == 8'h6E |=> reg_rdata == $past(sel); endproperty
  property p_stale; s_trig ##1 s_top |=> !reg_rdata[6]; endproperty
  property p_fresh; s_trig ##1 (!idx_wr) [*3] ##1 s_top |=> reg_rdata[6]; endproperty
  property p_drop; idx_wr && sel == 8'h1D ##1 (!idx_wr) [*4] ##1 reg_rd &&
    reg_addr == 8'h76 |=> reg_rdata == 8'h00; endproperty
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  property p_unmap; reg_rd && reg_addr > 8'h78 |=> reg_rdata == 8'h00; endproperty
  property p_rst; $fell(rst) |-> reg_rdata == 8'h00 && !fetch_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy pulse wrong");
  a_idle: assert property (p_idle) else $error("busy without trigger");
  a_sel_rd: assert property (p_sel_rd) else $error("select readback wrong");
  a_stale: assert property (p_stale) else $error("valid set early");
  a_fresh: assert property (p_fresh) else $error("valid not set");
  a_drop: assert property (p_drop) else $error("drop upper bits set");
  a_hold: assert property (p_hold) else $error("rdata moved");
  a_unmap: assert property (p_unmap) else $error("unmapped not zero");
  a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule // pscr_sva

bind pscr_stats_readout pscr_sva #(.PORTS(PORTS), .PER_PORT(PER_PORT)) u_sva (.clk(clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .stat_inc(stat_inc), .egress_discard_inc(egress_discard_inc),
  .ingress_discard_inc(ingress_discard_inc), .fetch_busy(fetch_busy));

// ===== tb/pscr_host.sv
module pscr_host (
  input wire clk, // clock
  input wire [7:0] reg_rdata, // rdata
  output reg [7:0] reg_addr, // address
  output reg reg_wr, // write
  output reg [7:0] reg_wdata, // wdata
  output reg reg_rd, // read
  output reg done, // word ready
  output reg [31:0] word // fetched word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_addr, reg_wr, reg_wdata, reg_rd, done, word} = 0;
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // now=1 reads in the capture cycle, deliberately catching the stale word;
  // discard fetches read only after the capture, as they carry no valid flag
  task rd(input [7:0] a, input now, output [7:0] d);
    if (!now) @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task fetch(input [7:0] s, input [7:0] i);
    reg [7:0] b3, b2, b1, b0;
    wr(8'h6E, s);
    wr(8'h6F, i);
    rd(8'h75, s == 8'h1C, b3);
    if (s == 8'h1C && !b3[6]) rd(8'h75, 1'b0, b3);
    rd(8'h76, 1'b0, b2);
    rd(8'h77, 1'b0, b1);
    rd(8'h78, 1'b0, b0);
    word <= {b3, b2, b1, b0};
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
endmodule // pscr_host

// ===== tb/pscr_stats_readout_tb.sv
module pscr_stats_readout_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [169:0] ev = '0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, fetch_busy, h_done;
  wire [31:0] h_word;
  reg [7:0] seed = 8'h5E;
  reg [7:0] b;
  reg [31:0] exp_q[$];
  integer mismatches = 0, num_checks = 0, k, n, j;
  always #50 clk = ~clk;
  pscr_stats_readout u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stat_inc(ev[159:0]),
    .egress_discard_inc(ev[164:160]), .ingress_discard_inc(ev[169:165]),
    .fetch_busy(fetch_busy));
  pscr_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .done(h_done), .word(h_word));
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task finish_test;
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cmp32(input [31:0] e, input [31:0] a);
    num_checks = num_checks + 1;
    if (a !== e) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t exp %h got %h", $time, e, a);
    end
  endtask
  task cmp8(input [7:0] e, input [7:0] a);
    num_checks = num_checks + 1;
    if (a !== e) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t exp %h got %h", $time, e, a);
    end
  endtask
  task bump(input integer bit_i, input integer cnt);
    repeat (cnt) begin
      @(posedge clk);
      ev[bit_i] <= 1'b1;
    end
    @(posedge clk);
    ev <= '0;
  endtask
  always @(posedge clk) if (h_done) cmp32(exp_q.pop_front(), h_word);
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 20; k = k + 1) begin
      seed = lfsr(seed);
      n = seed[2:0] + 1;
      if (k < 10) begin
        j = (k % 5) * 32 + ((k < 5) ? 14 : seed[7:3]);
        bump(j, n);
        exp_q.push_back(32'h40000000 | n);
        exp_q.push_back(32'h40000000);
        u_host.fetch(8'h1C, j[7:0]);
        u_host.fetch(8'h1C, j[7:0]);
      end else begin
        j = k - 10;
        bump(160 + j, n);
        exp_q.push_back(n);
        exp_q.push_back(n);
        u_host.fetch(8'h1D, j[7:0]);
        u_host.fetch(8'h1D, j[7:0]);
      end
    end
    u_host.rd(8'hF0, 1'b0, b);
    cmp8(8'h00, b);
    u_host.wr(8'h6E, 8'h1E);
    u_host.wr(8'h6F, 8'h0E);
    u_host.rd(8'h6E, 1'b0, b);
    cmp8(8'h1E, b);
    u_host.rd(8'h6F, 1'b0, b);
    cmp8(8'h0E, b);
    u_host.rd(8'h78, 1'b0, b);
    cmp8(n[7:0], b);
    repeat (2) @(posedge clk);
    finish_test;
  end
  initial begin
    #500000;
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule // pscr_stats_readout_tb
